// file: shared/agss_pkg.sv
// Purpose: Shared constants and types for the automatic grey-scale servo block.
// Assumes: One 250 MHz clock; all timing inputs are synchronous to it.
// Notes: Register map entries are word indices, taken from address bits 5:2 of a 32-bit AXI4-Lite bus.
package agss_pkg;
   // ==========================================================
   // Widths and codes
   typedef logic [6:0] agss_code_t;
   typedef logic [2:0] agss_tgt_t;
   localparam int unsigned NUM_CHAN = 3;
   localparam int unsigned NUM_LATCH = 7;
   localparam agss_code_t CODE_MAX = 7'h7F;
   localparam agss_code_t CODE_MIN = 7'h00;
   localparam agss_code_t INTENS_RST = 7'h20;
   localparam agss_code_t SERVO_RST = 7'h40;
   localparam agss_code_t ZERO_CODE = 7'h00;
   localparam agss_code_t DARK_DIVISOR = 7'h0A;
   localparam agss_code_t LIMIT_HI = 7'h70;
   localparam agss_code_t LIMIT_LO = 7'h08;
   // Latch targets: gain per channel, dc per channel, offset loop.
   localparam agss_tgt_t TGT_GAIN0 = 3'h0;
   localparam agss_tgt_t TGT_DC0 = 3'h3;
   localparam agss_tgt_t TGT_OFFSET = 3'h6;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned LINE_PERIOD_NS = 64000;
   localparam int unsigned HALF_LINE_DEFAULT = LINE_PERIOD_NS / CLK_PERIOD_NS / 2;
   localparam logic [13:0] SEQ_GAP = 14'h0004;
   localparam logic [9:0] SAMPLE_LINE_FIRST = 10'h014;
   localparam logic [9:0] SAMPLE_LINE_LAST = 10'h016;
   // ==========================================================
   // Register map
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_CONTRAST = 4'h1;
   localparam logic [3:0] IDX_BRIGHT = 4'h2;
   localparam logic [3:0] IDX_INTENS0 = 4'h3;
   localparam logic [3:0] IDX_STATUS = 4'h6;
   localparam logic [3:0] IDX_GAIN = 4'h7;
   localparam logic [3:0] IDX_DC = 4'h8;
   localparam logic [3:0] IDX_OFFSET = 4'h9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Sequencer carrier: interval start, interval finish and the latch addressed.
   typedef struct packed {
      logic start;
      logic finish;
      agss_tgt_t target;
   } agss_seq_t;
endpackage : agss_pkg

// file: design/agss_servo_cnt.sv
// Purpose: Seven-bit up/down servo counter with backload and deadband.
// Assumes: Comparator levels are synchronous; step is a one-cycle pulse.
// Notes: Saturates at both ends instead of wrapping.
`timescale 1ns/1ps
module agss_servo_cnt
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic backload,
   input wire agss_pkg::agss_code_t backload_val,
   input wire logic step,
   input wire logic err_up,
   input wire logic err_down,
   output agss_pkg::agss_code_t count
);
   import agss_pkg::*;
   // ==========================================================
   // Count logic
   // Only one of the two comparators may move the count; both high is treated as noise.
   wire go_up = step && err_up && !err_down && (count != CODE_MAX);
   wire go_down = step && err_down && !err_up && (count != CODE_MIN);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         count <= SERVO_RST;
      else if (backload)
         count <= backload_val;
      else if (go_up)
         count <= count + 7'h01;
      else if (go_down)
         count <= count - 7'h01;
   end
   // ==========================================================
   // Checks
   a_count_up: assert property (@(posedge clk) disable iff (!rst_n)
      (step && err_up && !err_down && !backload && count != CODE_MAX) |=> count == $past(count) + 7'h01)
      else $error("counter did not step up");
   a_count_down: assert property (@(posedge clk) disable iff (!rst_n)
      (step && err_down && !err_up && !backload && count != CODE_MIN) |=> count == $past(count) - 7'h01)
      else $error("counter did not step down");
   a_count_deadband: assert property (@(posedge clk) disable iff (!rst_n)
      (!backload && !err_up && !err_down) |=> $stable(count))
      else $error("counter moved inside the deadband");
   a_count_saturate: assert property (@(posedge clk) disable iff (!rst_n)
      (!backload && count == CODE_MAX && err_up) |=> count == CODE_MAX)
      else $error("counter wrapped past its top code");
endmodule : agss_servo_cnt

// file: design/agss_sequencer.sv
// Purpose: Load/backload sequencer that frames the adjustment intervals.
// Assumes: Line and field timing levels are synchronous to the clock.
// Notes: Bright and dark halves each open SEQ_GAP cycles after their boundary.
`timescale 1ns/1ps
module agss_sequencer
#(
   parameter int unsigned HALF_LINE_CYCLES = agss_pkg::HALF_LINE_DEFAULT
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic line_sync,
   input wire logic field_sync,
   input wire logic flyback,
   output agss_pkg::agss_seq_t seq
);
   import agss_pkg::*;
   localparam logic [13:0] HALF = 14'(HALF_LINE_CYCLES);
   logic line_d, field_d, fly_d, dark_open, bright_open;
   logic [9:0] line_cnt;
   logic [13:0] cyc;
   // ==========================================================
   // Edge and position decode
   wire line_rise = line_sync && !line_d;
   wire field_rise = field_sync && !field_d;
   wire sample_line = (line_cnt >= SAMPLE_LINE_FIRST) && (line_cnt <= SAMPLE_LINE_LAST);
   wire [2:0] chan = 3'(line_cnt - SAMPLE_LINE_FIRST);
   wire bright_start = sample_line && !line_rise && (cyc == SEQ_GAP);
   wire dark_start = sample_line && !line_rise && (cyc == HALF + SEQ_GAP);
   wire bright_end = bright_open && (line_rise || cyc == HALF);
   wire dark_end = dark_open && line_rise;
   wire fly_start = flyback && !fly_d;
   wire fly_end = !flyback && fly_d;
   // ==========================================================
   // Line and cycle counters; the line count restarts at each field.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_d <= 1'b0;
         field_d <= 1'b0;
         fly_d <= 1'b0;
         line_cnt <= 10'h000;
         cyc <= 14'h0000;
      end
      else
      begin
         line_d <= line_sync;
         field_d <= field_sync;
         fly_d <= flyback;
         line_cnt <= field_rise ? 10'h000 : (line_rise ? line_cnt + 10'h001 : line_cnt);
         cyc <= line_rise ? 14'h0000 : cyc + 14'h0001;
      end
   end
   // ==========================================================
   // Interval framing and latch addressing.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bright_open <= 1'b0;
         dark_open <= 1'b0;
         seq <= '0;
      end
      else
      begin
         bright_open <= bright_start || (bright_open && !bright_end);
         dark_open <= dark_start || (dark_open && !dark_end);
         seq.start <= bright_start || dark_start || fly_start;
         seq.finish <= bright_end || dark_end || fly_end;
         if (fly_start)
            seq.target <= TGT_OFFSET;
         else if (bright_start)
            seq.target <= TGT_GAIN0 + chan;
         else if (dark_start)
            seq.target <= TGT_DC0 + chan;
      end
   end
   a_seq_one_open: assert property (@(posedge clk) disable iff (!rst_n)
      !(bright_open && dark_open))
      else $error("bright and dark intervals overlap");
endmodule : agss_sequencer

// file: design/agss_top.sv
// Purpose: Digital control of the automatic grey-scale servo for three colour channels.
// Assumes: Comparator and timing inputs are synchronous to SYS_CLK; single AXI4-Lite master.
// Notes: Gain and offset drive codes leave as 7-bit words to external converters; the 8-bit dc drive carries the pedestal.
//
// Summary of operation
// - Hold an intensity word per colour channel and output it as reference code.
// - During bright interval output reference pulse sized by the latest contrast word.
// - Error above upper threshold increments the servo counter.
// - Error below lower threshold decrements the servo counter.
// - Error between thresholds leaves the counter unchanged, forming a deadband.
// - At load, copy the counter into the addressed latch driving that output.
// - During dark interval the reference is the intensity word divided by ten.
// - Line and field timing drive the sequencer that addresses the latches.
// - Backload copies the addressed latch into the counter before adjustment.
// - Brightness shifts all three dc pedestals equally, outside the servo loops.
// - Servo updates stop while the loop-disable bit is set.
// - An offset-compensation loop with its own latch runs only in field flyback.
// - Each reference is checked against limits; separate up and down grid flags.
// - Gain and dc values are seven bits, held in latches between samplings.
// - Sampling uses three consecutive lines, one per colour channel.
// - First half of a sampling line adjusts gain, second half dc level.
`timescale 1ns/1ps
module agss_top
#(
   parameter int unsigned HALF_LINE_CYCLES = agss_pkg::HALF_LINE_DEFAULT
)
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic LINE_SYNC,
   input wire logic FIELD_SYNC,
   input wire logic FLYBACK,
   input wire logic UPPER_ERROR_COMPARATOR,
   input wire logic LOWER_ERROR_COMPARATOR,
   output agss_pkg::agss_code_t [2:0] INTENSITY_REF,
   output agss_pkg::agss_code_t BRIGHT_PULSE,
   output agss_pkg::agss_code_t DARK_PULSE,
   output agss_pkg::agss_code_t [2:0] GAIN_DRIVE,
   output logic [2:0][7:0] DC_DRIVE,
   output agss_pkg::agss_code_t OFFSET_DRIVE,
   output logic [2:0] SCREEN_GRID_UP,
   output logic [2:0] SCREEN_GRID_DOWN
);
   import agss_pkg::*;
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_BLOAD = 4'b0010,
      ST_ADJ = 4'b0100,
      ST_LOAD = 4'b1000
   } agss_state_t;
   agss_state_t state, next_state;
   agss_seq_t seq;
   agss_tgt_t tgt;
   agss_code_t count;
   agss_code_t contrast, brightness;
   agss_code_t latch [NUM_LATCH];
   logic loop_disable;
   logic aw_full, w_full;
   logic [3:0] aw_idx;
   logic [31:0] w_data;
   logic w_strb0;

   // ==========================================================
   // Sequencer and servo counter
   agss_sequencer #(.HALF_LINE_CYCLES(HALF_LINE_CYCLES)) u_seq
   (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .line_sync(LINE_SYNC),
      .field_sync(FIELD_SYNC),
      .flyback(FLYBACK),
      .seq(seq)
   );

   // The step is taken once, on the interval's closing pulse, so a line moves a value by one code.
   wire do_backload = (state == ST_BLOAD);
   wire do_step = (state == ST_ADJ) && seq.finish && !loop_disable;
   agss_servo_cnt u_cnt
   (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .backload(do_backload),
      .backload_val(latch[tgt]),
      .step(do_step),
      .err_up(UPPER_ERROR_COMPARATOR),
      .err_down(LOWER_ERROR_COMPARATOR),
      .count(count)
   );

   // ==========================================================
   // Load/backload state machine
   // A start pulse arriving while a cycle is still running is dropped rather than queued.
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE: if (seq.start) next_state = ST_BLOAD;
         ST_BLOAD: next_state = ST_ADJ;
         ST_ADJ: if (seq.finish) next_state = ST_LOAD;
         ST_LOAD: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state <= ST_IDLE;
         tgt <= TGT_GAIN0;
      end
      else
      begin
         state <= next_state;
         if (state == ST_IDLE && seq.start)
            tgt <= seq.target;
      end
   end

   // ==========================================================
   // Servo latches: gain 0..2, dc 3..5, offset 6.
   // With the loops disabled the load writes back the unchanged backloaded value.
   generate
      for (genvar i = 0; i < NUM_LATCH; i++)
      begin : g_latch
         always_ff @(posedge SYS_CLK or negedge RST_N)
         begin
            if (!RST_N)
               latch[i] <= SERVO_RST;
            else if (state == ST_LOAD && tgt == 3'(i))
               latch[i] <= count;
         end
      end
   endgenerate

   // ==========================================================
   // Reference pulses for the active interval.
   wire gain_phase = (state == ST_ADJ) && (tgt < TGT_DC0);
   wire dark_phase = (state == ST_ADJ) && (tgt >= TGT_DC0) && (tgt < TGT_OFFSET);
   wire [2:0] dark_chan = 3'(tgt - TGT_DC0);
   wire agss_code_t dark_ref = INTENSITY_REF[dark_chan[1:0]] / DARK_DIVISOR;
   wire agss_code_t next_bright = gain_phase ? contrast : ZERO_CODE;
   wire agss_code_t next_dark = dark_phase ? dark_ref : ZERO_CODE;

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         BRIGHT_PULSE <= ZERO_CODE;
         DARK_PULSE <= ZERO_CODE;
         OFFSET_DRIVE <= SERVO_RST;
      end
      else
      begin
         BRIGHT_PULSE <= next_bright;
         DARK_PULSE <= next_dark;
         OFFSET_DRIVE <= latch[TGT_OFFSET];
      end
   end

   // ==========================================================
   // Per-channel drives and range flags.
   // The pedestal is added after the latch, so brightness never enters the servo loop.
   generate
      for (genvar c = 0; c < NUM_CHAN; c++)
      begin : g_chan
         wire [7:0] next_dc = {1'b0, latch[TGT_DC0 + c]} + {1'b0, brightness};
         always_ff @(posedge SYS_CLK or negedge RST_N)
         begin
            if (!RST_N)
            begin
               GAIN_DRIVE[c] <= SERVO_RST;
               DC_DRIVE[c] <= 8'h00;
               SCREEN_GRID_UP[c] <= 1'b0;
               SCREEN_GRID_DOWN[c] <= 1'b0;
            end
            else
            begin
               GAIN_DRIVE[c] <= latch[TGT_GAIN0 + c];
               DC_DRIVE[c] <= next_dc;
               SCREEN_GRID_UP[c] <= INTENSITY_REF[c] > LIMIT_HI;
               SCREEN_GRID_DOWN[c] <= INTENSITY_REF[c] < LIMIT_LO;
            end
         end
      end
   endgenerate

   // ==========================================================
   // AXI4-Lite write path: address and data held independently, committed together.
   wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   wire w_take = S_AXI_WVALID && S_AXI_WREADY;
   wire do_write = aw_full && w_full && !S_AXI_BVALID;
   wire wr_ok = (aw_idx <= IDX_OFFSET);
   wire wr_en = do_write && w_strb0;
   wire next_aw_full = aw_full ? !do_write : aw_take;
   wire next_w_full = w_full ? !do_write : w_take;

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_idx <= IDX_CTRL;
         w_data <= 32'h00000000;
         w_strb0 <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= RESP_OKAY;
      end
      else
      begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         S_AXI_AWREADY <= !next_aw_full;
         S_AXI_WREADY <= !next_w_full;
         if (aw_take)
            aw_idx <= S_AXI_AWADDR[5:2];
         if (w_take)
         begin
            w_data <= S_AXI_WDATA;
            w_strb0 <= S_AXI_WSTRB[0];
         end
         if (do_write)
         begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   // ==========================================================
   // Software-written control registers; only byte lane 0 carries meaning.
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         loop_disable <= 1'b0;
         contrast <= SERVO_RST;
         brightness <= ZERO_CODE;
      end
      else if (wr_en)
      begin
         if (aw_idx == IDX_CTRL)
            loop_disable <= w_data[0];
         if (aw_idx == IDX_CONTRAST)
            contrast <= w_data[6:0];
         if (aw_idx == IDX_BRIGHT)
            brightness <= w_data[6:0];
      end
   end

   generate
      for (genvar k = 0; k < NUM_CHAN; k++)
      begin : g_intens
         always_ff @(posedge SYS_CLK or negedge RST_N)
         begin
            if (!RST_N)
               INTENSITY_REF[k] <= INTENS_RST;
            else if (wr_en && aw_idx == IDX_INTENS0 + 4'(k))
               INTENSITY_REF[k] <= w_data[6:0];
         end
      end
   endgenerate

   // ==========================================================
   // AXI4-Lite read path: data one cycle after the address is taken.
   wire [3:0] ar_idx = S_AXI_ARADDR[5:2];
   wire [31:0] rd_status = {23'h0, state != ST_IDLE, 2'h0, SCREEN_GRID_DOWN, SCREEN_GRID_UP};
   wire [31:0] rd_gain = {9'h0, latch[2], 1'b0, latch[1], 1'b0, latch[0]};
   wire [31:0] rd_dc = {9'h0, latch[5], 1'b0, latch[4], 1'b0, latch[3]};
   wire [31:0] rd_data =
      (ar_idx == IDX_CTRL) ? {31'h0, loop_disable} :
      (ar_idx == IDX_CONTRAST) ? {25'h0, contrast} :
      (ar_idx == IDX_BRIGHT) ? {25'h0, brightness} :
      (ar_idx == IDX_INTENS0) ? {25'h0, INTENSITY_REF[0]} :
      (ar_idx == IDX_INTENS0 + 4'h1) ? {25'h0, INTENSITY_REF[1]} :
      (ar_idx == IDX_INTENS0 + 4'h2) ? {25'h0, INTENSITY_REF[2]} :
      (ar_idx == IDX_STATUS) ? rd_status :
      (ar_idx == IDX_GAIN) ? rd_gain :
      (ar_idx == IDX_DC) ? rd_dc :
      (ar_idx == IDX_OFFSET) ? {25'h0, latch[TGT_OFFSET]} : 32'h00000000;
   wire rd_ok = (ar_idx <= IDX_OFFSET);
   wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h00000000;
         S_AXI_RRESP <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_data;
         S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_RVALID)
      begin
         S_AXI_RVALID <= !S_AXI_RREADY;
         S_AXI_ARREADY <= S_AXI_RREADY;
      end
      else
         S_AXI_ARREADY <= 1'b1;
   end

   // ==========================================================
   // Checks
   sequence s_backload_cycle;
      (state == ST_BLOAD) ##1 (state == ST_ADJ);
   endsequence

   // The closing pulse of an interval while software holds the loops off.
   sequence s_disabled_close;
      (state == ST_ADJ) && seq.finish && loop_disable;
   endsequence

   a_backload_copy: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_backload_cycle |-> (count == $past(latch[tgt])))
      else $error("backload did not copy the addressed latch");
   a_load_copy: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (state == ST_LOAD) |=> (latch[$past(tgt)] == $past(count)))
      else $error("load did not copy the counter");
   a_loop_disable_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      s_disabled_close |=> $stable(count))
      else $error("counter moved while loops disabled");
   a_bright_pulse_level: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (gain_phase && $stable(contrast)) |=> (BRIGHT_PULSE == $past(contrast)))
      else $error("bright pulse does not follow contrast");
   a_dark_ref_scale: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (dark_phase && $stable(INTENSITY_REF)) |=>
      (DARK_PULSE == $past(INTENSITY_REF[dark_chan[1:0]]) / DARK_DIVISOR))
      else $error("dark reference is not intensity over ten");
   a_pedestal_equal: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      ($stable(brightness) && $stable(latch[3])) |=>
      (DC_DRIVE[0] == {1'b0, $past(latch[3])} + {1'b0, $past(brightness)}))
      else $error("dc drive does not carry the pedestal");
   a_grid_flag_up: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (INTENSITY_REF[0] > LIMIT_HI) ##1 (INTENSITY_REF[0] > LIMIT_HI) |-> SCREEN_GRID_UP[0] && !SCREEN_GRID_DOWN[0])
      else $error("grid up flag missing");
endmodule : agss_top

// file: verif/agss_cathode_model.sv
// Purpose: Cathode amplifier feedback model giving the two error comparator levels.
// Assumes: The bench picks the error direction for each field.
// Notes: dir 1 = above upper threshold, 2 = below lower threshold, else deadband.
`timescale 1ns/1ps
module agss_cathode_model
(
   input wire logic clk,
   input wire logic [1:0] dir,
   output logic upper_error_comparator,
   output logic lower_error_comparator
);
   // ==========================================
   // Comparators
   // Registered so the levels settle long before any interval closes.
   always_ff @(posedge clk)
   begin
      upper_error_comparator <= (dir == 2'h1);
      lower_error_comparator <= (dir == 2'h2);
   end
endmodule : agss_cathode_model

// file: verif/auto_gray_scale_servo_tb.sv
// Purpose: Self-checking bench for the grey-scale servo top.
// Assumes: Short half line of 40 cycles; one AXI4-Lite master.
// Notes: Saturation needs over 60 fields, so saturation at the top code is left to the design assertions.
`timescale 1ns/1ps
module auto_gray_scale_servo_tb;
   import agss_pkg::*;
   typedef struct {logic [1:0] d; logic dis; agss_code_t e;} agss_row_t;
   logic clk, rst_n, awv, wv, br, arv, rr, lsync, fsync, fly, up, dn, awr, wrd, bv, arr, rv;
   logic [7:0] aa, ra;
   logic [31:0] wd, rdat, d;
   logic [1:0] bresp, rresp, r, dir;
   agss_code_t [2:0] iref, gain;
   agss_code_t bp, dp, offs;
   logic [2:0][7:0] dc;
   logic [2:0] gup, gdn;
   int fail_count, samples_checked, cyc;
   // Rows: error direction, loop disable, code expected after the field.
   agss_row_t rows [4] = '{'{2'h1, 1'b0, 7'h41}, '{2'h2, 1'b0, 7'h40}, '{2'h0, 1'b0, 7'h40}, '{2'h1, 1'b1, 7'h40}};
   agss_top #(.HALF_LINE_CYCLES(40)) i_dut (.SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(aa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ra), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
      .LINE_SYNC(lsync), .FIELD_SYNC(fsync), .FLYBACK(fly), .UPPER_ERROR_COMPARATOR(up),
      .LOWER_ERROR_COMPARATOR(dn), .INTENSITY_REF(iref), .BRIGHT_PULSE(bp), .DARK_PULSE(dp), .GAIN_DRIVE(gain),
      .DC_DRIVE(dc), .OFFSET_DRIVE(offs), .SCREEN_GRID_UP(gup), .SCREEN_GRID_DOWN(gdn));
   agss_cathode_model i_far (.clk(clk), .dir(dir), .upper_error_comparator(up), .lower_error_comparator(dn));
   // ==========================================
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // A stuck handshake or sequencer ends the run here as a failure.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         test_done();
      end
   end
   // ==========================================
   // Tasks
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      aa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      // Only the bench timeout ends a wait for the response.
      while (bv !== 1'b1)
      begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
      end
      r = bresp;
      br <= 1'b0;
      @(posedge clk);
   endtask : axw
   task automatic axr(input logic [7:0] a);
      ra <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      while (rv !== 1'b1)
      begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end
      d = rdat;
      r = rresp;
      rr <= 1'b0;
      @(posedge clk);
   endtask : axr
   // One 60-cycle line; the first sampling line also has its pulses checked.
   task automatic line(input int k);
      lsync <= 1'b1;
      @(posedge clk);
      lsync <= 1'b0;
      repeat (20) @(posedge clk);
      if (k == 20) chk(bp === 7'h50, "bright pulse");
      repeat (30) @(posedge clk);
      if (k == 20) chk(dp === 7'h0A, "dark pulse");
      repeat (9) @(posedge clk);
   endtask : line
   task automatic field(input logic [1:0] e);
      dir <= e;
      fly <= 1'b1;
      repeat (30) @(posedge clk);
      fly <= 1'b0;
      fsync <= 1'b1;
      @(posedge clk);
      fsync <= 1'b0;
      for (int k = 1; k <= 24; k++) line(k);
   endtask : field
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   // ==========================================
   // Main sequence
   initial
   begin
      {rst_n, awv, wv, br, arv, rr, lsync, fsync, fly} = '0;
      {aa, ra, wd, dir} = '0;
      repeat (3) @(posedge clk);
      chk(gain[0] === SERVO_RST && iref[2] === INTENS_RST && offs === SERVO_RST, "reset values");
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      axw(8'h04, 32'h50);
      axw(8'h08, 32'h05);
      axw(8'h0C, 32'h64);
      chk(iref[0] === 7'h64 && iref[1] === INTENS_RST && r === RESP_OKAY, "intensity");
      // Each row enables or disables the loops, then runs one full field.
      for (int i = 0; i < 4; i++)
      begin
         axw(8'h00, {31'h0, rows[i].dis});
         field(rows[i].d);
         for (int c = 0; c < 3; c++)
            chk(gain[c] === rows[i].e && dc[c] === {1'b0, rows[i].e} + 8'h05, "servo codes");
         chk(offs === rows[i].e, "offset code");
      end
      axw(8'h0C, 32'h75);
      axw(8'h10, 32'h05);
      chk(gup === 3'h1 && gdn === 3'h2, "grid flags");
      axr(8'h18);
      chk(d === 32'h11 && r === RESP_OKAY, "status read");
      axr(8'h30);
      chk(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
      axw(8'h30, 32'h1);
      chk(r === RESP_SLVERR, "unmapped write");
      // Mid-run reset: every drive returns to its reset code, then the bus must answer again.
      rst_n <= 1'b0;
      @(posedge clk);
      chk(iref[0] === INTENS_RST && gain[1] === SERVO_RST && dc[2] === 8'h00 && gup === 3'h0, "mid reset");
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(dc[0] === {1'b0, SERVO_RST} && bp === ZERO_CODE && gdn === 3'h0, "drives after reset");
      axr(8'h04);
      chk(d === {25'h0, SERVO_RST} && r === RESP_OKAY, "contrast after reset");
      test_done();
   end
endmodule : auto_gray_scale_servo_tb
